/* File: src/afm_pkg.sv */
/*
 * Shared constants for the all-frame mode tracker: packet layout,
 * packet kinds, vector codes, link timing and the host register map.
 * Assumes both ends and the bench import this package.
 */
package afm_pkg;

    // ----------------------------------------------------------------
    // link packets
    // ----------------------------------------------------------------
    localparam int PKT_W = 16;
    localparam int KIND_HI = 15;
    localparam int KIND_LO = 12;
    localparam logic [3:0] KIND_NOP = 4'h0;
    localparam logic [3:0] KIND_AFM = 4'h1;
    localparam logic [3:0] KIND_VEC = 4'h2;
    localparam logic [3:0] KIND_STAT = 4'h3;
    localparam int AFM_DAF = 0;
    localparam int AFM_FAF = 1;
    localparam int AFM_DTA = 2;
    localparam int AFM_IDX_LO = 3;
    localparam int TA_W = 4;
    localparam int NUM_TEMP = 16;
    localparam int STAT_EOF = 11;
    localparam int FRAME_W = 7;
    localparam logic [2:0] VEC_SECURE = 3'h0;
    localparam logic [2:0] VEC_ALPHA = 3'h5;
    localparam logic [2:0] VEC_HEXBIN = 3'h6;
    localparam logic [4:0] BITS_PER_PKT = 5'h10;

    // ----------------------------------------------------------------
    // link timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // host register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] REG_STATE = 8'h18;
    localparam int CTRL_FAF = 0;
    localparam int CTRL_LIM = 1;
    localparam int CMD_CNT_LO = 0;
    localparam int CMD_CNT_W = 4;
    localparam int CMD_DTA = 4;
    localparam int CMD_IDX_LO = 8;
    localparam int IRQ_VEC = 0;
    localparam int IRQ_EOF = 1;
    localparam int IRQ_GAP = 2;
    localparam int IRQ_DONE = 3;
    localparam int IRQ_W = 4;
    localparam int GAP_W = 8;
    localparam logic [7:0] GAP_SHORT = 8'h20;
    localparam logic [7:0] GAP_LONG = 8'h80;
    localparam int STATE_BUSY = 0;
    localparam int STATE_LIVE = 1;
    localparam int STATE_GAP_LO = 8;

    // vector codes that open a possibly fragmented message
    function automatic logic afm_is_frag_vec(input logic [2:0] code);
        return (code == VEC_SECURE) || (code == VEC_ALPHA) || (code == VEC_HEXBIN);
    endfunction : afm_is_frag_vec

endpackage : afm_pkg

/* File: src/afm_link_if.sv */
/*
 * Serial packet link between decoder and host.
 * Assumes the bench instantiates it and connects both ends.
 */
interface afm_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic miso;
    logic reqN;

    modport device (input sclk, input csN, input mosi, output miso, output reqN);
    modport host (output sclk, output csN, output mosi, input miso, input reqN);
endinterface : afm_link_if

/* File: src/afm_sync3.sv */
/*
 * Three-flop input synchroniser; a bit changes once stages two and
 * three agree. Assumes inputs are asynchronous to core_clk.
 */
module afm_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import afm_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } afm_sync_t;

    afm_sync_t st;
    afm_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule : afm_sync3

/* File: src/afm_device.sv */
/*
 * Decoder end: all-frame counter, temporary address counters and the
 * serial slave that sends vector and status packets.
 * Assumes the host clocks every packet and drives the link.
 */
module afm_device #(
    parameter int CW = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    afm_link_if.device link,
    input wire logic vecValid,
    input wire logic [2:0] vecCode,
    input wire logic frameEnd,
    input wire logic [afm_pkg::FRAME_W-1:0] frameNum,
    output logic evReady,
    input wire logic tempValid,
    input wire logic [afm_pkg::TA_W-1:0] tempIdx,
    output logic allFrameMode,
    output logic [CW-1:0] allFrameCount,
    output logic forceAllFrame
);
    import afm_pkg::*;

    typedef struct packed {
        logic sclkPrev;
        logic csPrev;
        logic [PKT_W-1:0] shTx;
        logic [PKT_W-1:0] shRx;
        logic [4:0] bitCnt;
        logic miso;
        logic reqN;
        logic pend;
        logic [PKT_W-1:0] txWord;
        logic rdy;
        logic [CW-1:0] afCnt;
        logic [NUM_TEMP-1:0][CW-1:0] tempCnt;
        logic faf;
        logic afMode;
    } afm_dev_t;

    afm_dev_t st;
    afm_dev_t next_st;
    logic [2:0] linkQ;
    logic sclkQ;
    logic csQ;
    logic mosiQ;
    logic anyTemp;
    logic [PKT_W-1:0] rxWord;

    // ----------------------------------------------------------------
    // link input synchroniser
    // ----------------------------------------------------------------
    afm_sync3 #(.W(3), .INIT(3'h2)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({link.sclk, link.csN, link.mosi}),
        .q(linkQ)
    );
    assign sclkQ = linkQ[2];
    assign csQ = linkQ[1];
    assign mosiQ = linkQ[0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        anyTemp = 1'b0;
        rxWord = st.shRx;
        next_st.sclkPrev = sclkQ;
        next_st.csPrev = csQ;
        // frame start: load pending packet
        if (st.csPrev && !csQ) begin
            next_st.shTx = st.pend ? st.txWord : '0;
            next_st.miso = st.pend ? st.txWord[PKT_W-1] : 1'b0;
            next_st.pend = 1'b0;
            next_st.bitCnt = '0;
        end else if (!csQ) begin
            if (sclkQ && !st.sclkPrev) begin
                next_st.shRx = {st.shRx[PKT_W-2:0], mosiQ};
                next_st.bitCnt = st.bitCnt + 5'h01;
            end
            if (!sclkQ && st.sclkPrev) begin
                next_st.shTx = {st.shTx[PKT_W-2:0], 1'b0};
                next_st.miso = st.shTx[PKT_W-2];
            end
        end
        // events: vector wins over end of frame
        if (vecValid && st.rdy) begin
            if (afm_is_frag_vec(vecCode) && st.afCnt != '1) begin
                next_st.afCnt = st.afCnt + 1'b1;
            end
            next_st.txWord = {KIND_VEC, 9'h000, vecCode};
            next_st.pend = 1'b1;
        end else if (frameEnd && st.rdy && st.afMode) begin
            next_st.txWord = {KIND_STAT, 1'b1, 4'h0, frameNum};
            next_st.pend = 1'b1;
        end
        if (tempValid && st.tempCnt[tempIdx] != '1) begin
            next_st.tempCnt[tempIdx] = st.tempCnt[tempIdx] + 1'b1;
        end
        // completed host packet
        if (!st.csPrev && csQ && st.bitCnt == BITS_PER_PKT
                && rxWord[KIND_HI:KIND_LO] == KIND_AFM) begin
            next_st.faf = rxWord[AFM_FAF];
            if (rxWord[AFM_DAF] && next_st.afCnt != '0) begin
                next_st.afCnt = next_st.afCnt - 1'b1;
            end
            if (rxWord[AFM_DTA]
                    && next_st.tempCnt[rxWord[AFM_IDX_LO+:TA_W]] != '0) begin
                next_st.tempCnt[rxWord[AFM_IDX_LO+:TA_W]] =
                    next_st.tempCnt[rxWord[AFM_IDX_LO+:TA_W]] - 1'b1;
            end
        end
        for (int i = 0; i < NUM_TEMP; i++) begin
            if (next_st.tempCnt[i] != '0) begin
                anyTemp = 1'b1;
            end
        end
        next_st.afMode = (next_st.afCnt != '0) || anyTemp || next_st.faf;
        next_st.rdy = !next_st.pend;
        next_st.reqN = !next_st.pend;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.sclkPrev <= 1'b0;
            st.csPrev <= 1'b1;
            st.reqN <= 1'b1;
            st.rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.miso = st.miso;
    assign link.reqN = st.reqN;
    assign evReady = st.rdy;
    assign allFrameMode = st.afMode;
    assign allFrameCount = st.afCnt;
    assign forceAllFrame = st.faf;
endmodule : afm_device

/* File: src/afm_host.sv */
/*
 * Host end: link master that makes the serial clock, sends all-frame
 * mode packets and collects decoder packets; software reaches it over
 * APB. Assumes a single APB master and the decoder as link slave.
 */
// The register addresses and register access over APB were chosen for this implementation.
module afm_host #(
    parameter int HALF = afm_pkg::LINK_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    afm_link_if.host link,
    input wire logic [afm_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import afm_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_SETUP = 5'b00010,
        H_HIGH = 5'b00100,
        H_LOW = 5'b01000,
        H_GAP = 5'b10000
    } afm_hstate_t;

    typedef struct packed {
        afm_hstate_t state;
        logic [7:0] div;
        logic [4:0] bitCnt;
        logic sclk;
        logic csN;
        logic mosi;
        logic [PKT_W-1:0] shTx;
        logic [PKT_W-1:0] shRx;
        logic txCmd;
        logic faf;
        logic lim128;
        logic [CMD_CNT_W-1:0] cmdLeft;
        logic cmdGo;
        logic cmdDta;
        logic [TA_W-1:0] cmdIdx;
        logic [PKT_W-1:0] rxData;
        logic fragLive;
        logic [GAP_W-1:0] gapCnt;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqEn;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } afm_host_t;

    afm_host_t st;
    afm_host_t next_st;
    logic [1:0] linkQ;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [GAP_W-1:0] gapLim;
    logic halfDone;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL || a == REG_CMD || a == REG_RXDATA || a == REG_IRQ_STAT
            || a == REG_IRQ_EN || a == REG_IRQ_CLR || a == REG_STATE;
    endfunction : reg_mapped

    function automatic logic [31:0] reg_read(input afm_host_t s, input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = '0;
        case (a)
            REG_CTRL: begin
                v[CTRL_FAF] = s.faf;
                v[CTRL_LIM] = s.lim128;
            end
            REG_CMD: begin
                v[CMD_CNT_LO+:CMD_CNT_W] = s.cmdLeft;
                v[CMD_DTA] = s.cmdDta;
                v[CMD_IDX_LO+:TA_W] = s.cmdIdx;
            end
            REG_RXDATA: v[PKT_W-1:0] = s.rxData;
            REG_IRQ_STAT: v[IRQ_W-1:0] = s.irqStat;
            REG_IRQ_EN: v[IRQ_W-1:0] = s.irqEn;
            REG_STATE: begin
                v[STATE_BUSY] = s.cmdGo;
                v[STATE_LIVE] = s.fragLive;
                v[STATE_GAP_LO+:GAP_W] = s.gapCnt;
            end
            default: v = '0;
        endcase
        return v;
    endfunction : reg_read

    // ----------------------------------------------------------------
    // link input synchroniser
    // ----------------------------------------------------------------
    afm_sync3 #(.W(2), .INIT(2'h1)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({link.miso, link.reqN}),
        .q(linkQ)
    );

    assign halfDone = (st.div == 8'(HALF - 1));
    assign gapLim = st.lim128 ? GAP_LONG : GAP_SHORT;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        ev = '0;
        clr = '0;
        next_st.div = halfDone ? 8'h00 : st.div + 8'h01;
        case (st.state)
            H_IDLE: begin
                next_st.div = '0;
                if (st.cmdGo || !linkQ[0]) begin
                    next_st.txCmd = st.cmdGo;
                    next_st.shTx = '0;
                    if (st.cmdGo) begin
                        next_st.shTx[KIND_HI:KIND_LO] = KIND_AFM;
                        next_st.shTx[AFM_DAF] = (st.cmdLeft != '0);
                        next_st.shTx[AFM_FAF] = st.faf;
                        next_st.shTx[AFM_DTA] = st.cmdDta;
                        next_st.shTx[AFM_IDX_LO+:TA_W] = st.cmdIdx;
                    end else begin
                        next_st.shTx[AFM_FAF] = st.faf;
                        next_st.shTx[KIND_HI:KIND_LO] = KIND_NOP;
                    end
                    next_st.mosi = next_st.shTx[PKT_W-1];
                    next_st.csN = 1'b0;
                    next_st.bitCnt = '0;
                    next_st.state = H_SETUP;
                end
            end
            H_SETUP, H_LOW: begin
                if (halfDone) begin
                    next_st.sclk = 1'b1;
                    next_st.shRx = {st.shRx[PKT_W-2:0], linkQ[1]};
                    next_st.bitCnt = st.bitCnt + 5'h01;
                    next_st.state = H_HIGH;
                end
            end
            H_HIGH: begin
                if (halfDone) begin
                    next_st.sclk = 1'b0;
                    next_st.shTx = {st.shTx[PKT_W-2:0], 1'b0};
                    next_st.mosi = st.shTx[PKT_W-2];
                    if (st.bitCnt == BITS_PER_PKT) begin
                        next_st.csN = 1'b1;
                        next_st.state = H_GAP;
                    end else begin
                        next_st.state = H_LOW;
                    end
                end
            end
            H_GAP: begin
                if (halfDone) begin
                    next_st.state = H_IDLE;
                    next_st.rxData = st.shRx;
                    if (st.shRx[KIND_HI:KIND_LO] == KIND_VEC) begin
                        ev[IRQ_VEC] = 1'b1;
                        if (afm_is_frag_vec(st.shRx[2:0])) begin
                            next_st.fragLive = 1'b1;
                            next_st.gapCnt = '0;
                        end
                    end
                    if (st.shRx[KIND_HI:KIND_LO] == KIND_STAT && st.shRx[STAT_EOF]) begin
                        ev[IRQ_EOF] = 1'b1;
                        if (st.fragLive) begin
                            next_st.gapCnt = st.gapCnt + 8'h01;
                            if (next_st.gapCnt == gapLim) begin
                                ev[IRQ_GAP] = 1'b1;
                                next_st.fragLive = 1'b0;
                            end
                        end
                    end
                    // one decrement packet per count, e.g. two at the last fragment
                    if (st.txCmd) begin
                        next_st.cmdDta = 1'b0;
                        if (st.cmdLeft > 1) begin
                            next_st.cmdLeft = st.cmdLeft - 1'b1;
                        end else begin
                            next_st.cmdLeft = '0;
                            next_st.cmdGo = 1'b0;
                            ev[IRQ_DONE] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_st.state = H_IDLE;
                next_st.sclk = 1'b0;
                next_st.csN = 1'b1;
            end
        endcase
        // apb: answer one cycle into the access phase
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !reg_mapped(paddr);
            next_st.prdata = pwrite ? 32'h0000_0000 : reg_read(st, paddr);
        end else begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end
        if (psel && penable && st.pready && pwrite) begin
            case (paddr)
                REG_CTRL: begin
                    next_st.faf = pwdata[CTRL_FAF];
                    next_st.lim128 = pwdata[CTRL_LIM];
                end
                REG_CMD: begin
                    // software decides when to decrement; ignored while busy
                    if (!st.cmdGo) begin
                        next_st.cmdGo = 1'b1;
                        next_st.cmdLeft = pwdata[CMD_CNT_LO+:CMD_CNT_W];
                        next_st.cmdDta = pwdata[CMD_DTA];
                        next_st.cmdIdx = pwdata[CMD_IDX_LO+:TA_W];
                        if (pwdata[CMD_CNT_LO+:CMD_CNT_W] != '0) begin
                            next_st.fragLive = 1'b0;
                        end
                    end
                end
                REG_IRQ_EN: next_st.irqEn = pwdata[IRQ_W-1:0];
                REG_IRQ_CLR: clr = pwdata[IRQ_W-1:0];
                default: next_st.irqEn = st.irqEn;
            endcase
        end
        // set wins over clear
        next_st.irqStat = (st.irqStat & ~clr) | ev;
        next_st.irq = |(next_st.irqStat & next_st.irqEn);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.state <= H_IDLE;
            st.csN <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.sclk = st.sclk;
    assign link.csN = st.csN;
    assign link.mosi = st.mosi;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
endmodule : afm_host

/* File: tb/afm_link_monitor.sv */
/*
 * Checker for the decoder counter outputs and the serial link.
 * Assumes the testbench instantiates it beside the link interface.
 */
module afm_link_monitor
    import afm_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic reqN,
    input wire logic vecValid,
    input wire logic [2:0] vecCode,
    input wire logic frameEnd,
    input wire logic evReady,
    input wire logic allFrameMode,
    input wire logic [CW-1:0] allFrameCount,
    input wire logic forceAllFrame
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_vec;
        vecValid && evReady;
    endsequence
    sequence s_eof;
        frameEnd && evReady && !vecValid && allFrameMode;
    endsequence

    frag_inc_a: assert property (s_vec ##0 afm_is_frag_vec(vecCode) |=>
        allFrameCount != 0 && allFrameMode) else $error("count not raised by vector");
    plain_vec_a: assert property (s_vec ##0 (!afm_is_frag_vec(vecCode) && allFrameCount == 0)
        |=> allFrameCount == 0) else $error("count raised by other vector");
    eof_pkt_a: assert property (s_eof |=> !reqN && !evReady)
        else $error("frame end not queued");
    count_step_a: assert property (allFrameCount != $past(allFrameCount) |->
        allFrameCount == $past(allFrameCount) + 1'b1 || allFrameCount == $past(allFrameCount) - 1'b1)
        else $error("count moved by more than one");
    no_wrap_a: assert property (allFrameCount != 0 && $past(allFrameCount) == 0 |->
        allFrameCount == 1) else $error("count wrapped below zero");
    mode_hold_a: assert property ((allFrameCount != 0 || forceAllFrame) |-> ##[0:1] allFrameMode)
        else $error("normal selection while count or force set");
    lead_in_a: assert property ($fell(csN) |-> !sclk [*4])
        else $error("link clock rose too early");
    pkt_len_a: assert property ($fell(csN) |-> !csN [*8])
        else $error("packet select too short");
    idle_clk_a: assert property (csN |-> !sclk)
        else $error("link clock runs outside packet");
endmodule : afm_link_monitor

/* File: tb/testbench.sv */
/*
 * Testbench: decoder and host joined by the link, APB tasks on the host.
 * Assumes the design package and both ends compile before it.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import afm_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic vecValid = 1'b0;
    logic [2:0] vecCode = 3'h0;
    logic frameEnd = 1'b0;
    logic [FRAME_W-1:0] frameNum = 7'h00;
    logic tempValid = 1'b0;
    logic [TA_W-1:0] tempIdx = 4'h0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic evReady, allFrameMode, forceAllFrame, pready, pslverr, irq, err;
    logic [7:0] allFrameCount;
    logic [31:0] prdata, rd;
    int num_errors = 0;
    int check_count = 0;
    int expCount = 0;

    always #12.5 core_clk = ~core_clk;

    afm_link_if link();
    afm_device i_afm_device (.core_clk(core_clk), .rst(rst), .link(link), .vecValid(vecValid),
        .vecCode(vecCode), .frameEnd(frameEnd), .frameNum(frameNum), .evReady(evReady),
        .tempValid(tempValid), .tempIdx(tempIdx), .allFrameMode(allFrameMode),
        .allFrameCount(allFrameCount), .forceAllFrame(forceAllFrame));
    afm_host i_afm_host (.core_clk(core_clk), .rst(rst), .link(link), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    afm_link_monitor #(.CW(8)) i_afm_link_monitor (.core_clk(core_clk), .rst(rst),
        .sclk(link.sclk), .csN(link.csN), .reqN(link.reqN), .vecValid(vecValid),
        .vecCode(vecCode), .frameEnd(frameEnd), .evReady(evReady), .allFrameMode(allFrameMode),
        .allFrameCount(allFrameCount), .forceAllFrame(forceAllFrame));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic timed_out();
        num_errors++;
        conclude();
    endtask : timed_out

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) timed_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(input int b);
        int n;
        n = 0;
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        while (rd[b] !== 1'b1) begin
            n++;
            if (n > 400) timed_out();
            apb(1'b0, REG_IRQ_STAT, 32'h0);
        end
    endtask : wait_irq

    task automatic cmd(input logic [31:0] v);
        apb(1'b1, REG_CMD, v);
        wait_irq(IRQ_DONE);
        apb(1'b1, REG_IRQ_CLR, 32'h1 << IRQ_DONE);
    endtask : cmd

    task automatic ev(input logic isVec, input logic [2:0] c, input logic [6:0] f);
        int n;
        n = 0;
        @(posedge core_clk);
        vecValid <= isVec;
        vecCode <= c;
        frameEnd <= !isVec;
        frameNum <= f;
        do begin
            @(posedge core_clk);
            n++;
        end while (evReady !== 1'b1 && n < 2000);
        if (n >= 2000) timed_out();
        vecValid <= 1'b0;
        frameEnd <= 1'b0;
    endtask : ev

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(32'({allFrameCount, allFrameMode, irq}), 32'h0);
        chk(32'({link.sclk, link.csN, link.reqN}), 32'h3);
        $display("test reset done");
        apb(1'b1, REG_IRQ_EN, 32'h1 << IRQ_VEC);
        for (int c = 7; c >= 0; c--) begin
            ev(1'b1, 3'(c), 7'h00);
            if (c == 0 || c == 5 || c == 6) expCount++;
            wait_irq(IRQ_VEC);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, REG_RXDATA, 32'h0);
            chk(rd, {16'h0, KIND_VEC, 9'h0, 3'(c)});
            chk({24'h0, allFrameCount}, 32'(expCount));
            apb(1'b1, REG_IRQ_CLR, 32'h1 << IRQ_VEC);
            apb(1'b0, REG_IRQ_STAT, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("test vectors done");
        ev(1'b0, 3'h0, 7'h2a);
        wait_irq(IRQ_EOF);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, REG_RXDATA, 32'h0);
        chk(rd, 32'h0000382a);
        apb(1'b1, REG_IRQ_CLR, 32'h1 << IRQ_EOF);
        apb(1'b0, REG_STATE, 32'h0);
        chk(rd, 32'h00000102);
        for (int k = 1; k < GAP_SHORT; k++) begin
            ev(1'b0, 3'h0, 7'(k));
            wait_irq(IRQ_EOF);
            apb(1'b1, REG_IRQ_CLR, 32'h1 << IRQ_EOF);
        end
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h1 << IRQ_GAP);
        apb(1'b1, REG_IRQ_CLR, 32'h1 << IRQ_GAP);
        $display("test frame end done");
        cmd(32'h2);
        chk({23'h0, allFrameCount, allFrameMode}, 32'h3);
        apb(1'b1, REG_CTRL, 32'h1);
        cmd(32'h1);
        chk(32'({allFrameCount, forceAllFrame, allFrameMode}), 32'h3);
        apb(1'b1, REG_CTRL, 32'h0);
        cmd(32'h0);
        chk(32'({allFrameCount, forceAllFrame, allFrameMode}), 32'h0);
        cmd(32'h1);
        chk({24'h0, allFrameCount}, 32'h0);
        $display("test decrement done");
        ev(1'b0, 3'h0, 7'h11);
        repeat (20) @(posedge core_clk);
        chk({31'h0, link.reqN}, 32'h1);
        @(posedge core_clk);
        tempValid <= 1'b1;
        tempIdx <= 4'h3;
        @(posedge core_clk);
        tempValid <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'({allFrameCount, allFrameMode}), 32'h1);
        cmd((32'h3 << CMD_IDX_LO) | (32'h1 << CMD_DTA));
        chk({31'h0, allFrameMode}, 32'h0);
        $display("test temporary address done");
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("test unmapped done");
        conclude();
    end
endmodule : testbench
